// file: logic/mlut_params.svh
`ifndef MLUT_PARAMS_SVH
`define MLUT_PARAMS_SVH
// register offsets
`define MLUT_OFF_INDEX0 12'h0410
`define MLUT_OFF_INDEX1 12'h0414
`define MLUT_OFF_CTRL 12'h0418
`define MLUT_OFF_WORD1 12'h0420
`define MLUT_OFF_WORD2 12'h0424
`define MLUT_OFF_WORD3 12'h0428
`define MLUT_OFF_WORD4 12'h042C
// control register fields
`define MLUT_CTRL_OP_LSB 0
`define MLUT_CTRL_DIRECT 2
`define MLUT_CTRL_FOUND 5
`define MLUT_CTRL_FOSD 6
`define MLUT_CTRL_GO 7
`define MLUT_CTRL_CNT_LSB 16
// operation codes
`define MLUT_OP_WRITE 2'h1
`define MLUT_OP_READ 2'h2
`define MLUT_OP_SEARCH 2'h3
// reset values and counts
`define MLUT_RST_WORD 32'h0000_0000
`define MLUT_AGE_DEFAULT 3'h7
`define MLUT_WAYS 4
`define MLUT_BKT_W 10
`endif

// file: logic/mlut_pkg.sv
/*
 * Types shared by the address lookup table.
 * Assumes mlut_params.svh is included by the design file.
 */
package mlut_pkg;
    typedef struct packed {
        logic pinned;
        logic src_drop;
        logic dst_drop;
        logic [2:0] prio_age;
        logic [2:0] stg;
        logic psa;
        logic [6:0] fwd;
        logic [6:0] vlan_filter_group;
        logic [47:0] mac;
    } mlut_entry_t;

    typedef struct packed {
        logic hit;
        logic [1:0] hit_way;
        logic free;
        logic [1:0] free_way;
        logic vict_ok;
        logic [1:0] vict_way;
        logic [2:0] n_static;
    } mlut_scan_t;

    typedef enum logic [1:0] {S_IDLE, S_RW, S_SCAN, S_HOLD} mlut_state_t;
endpackage

// file: logic/mlut_top.sv
/*
 * Hashed 4-way MAC address lookup table with host access engine.
 * Assumes lookup requests and register strobes come from logic on clk_i.
 */
// Operation
// - 4-way store, 1K buckets, 4K entries
// - hash MAC and optional group to bucket
// - fill free way, else replace LRU dynamic
// - third or fourth static raises almost-full, address
// - fifth static write fails, bucket index reported
// - full static bucket blocks learning, index reported
// - destination searches all; source learns, ages, migrates
// - static destination result beats dynamic
// - all readable, only static writable, never aged
// - hashed, direct and sequential search access
// - op code, direct select, go bit launch
// - go clears on completion; found reports result
// - one combined found-or-done status bit
// - missed read returns zero entry words
// - search restarts at top, skips invalid
// - reading word 4 resumes the search
// - go holds during search; host may abort
// - ended search reads zeros, count reported
// - word 1 field layout
// - age reload on use, decrement, zero invalid
// - source and destination match drop flags
// - word 2 field layout
// - word 3 and word 4 field layout
`timescale 1ns/1ps
`include "mlut_params.svh"
module mlut_top import mlut_pkg::*; #(
    parameter logic [2:0] AGE_RELOAD = `MLUT_AGE_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    input wire logic vlan_en_i,
    input wire logic age_tick_i,
    input wire logic lk_req_i,
    input wire logic lk_src_i,
    input wire logic [47:0] lk_mac_i,
    input wire logic [6:0] lk_fid_i,
    input wire logic [6:0] lk_port_i,
    input wire logic st_hit_i,
    input wire logic [6:0] st_fwd_i,
    output logic lk_done_o,
    output logic lk_hit_o,
    output logic [6:0] lk_fwd_o,
    output logic lk_drop_o,
    output logic almost_full_o,
    output logic write_fail_o,
    output logic learn_fail_o
);
    localparam int NENT = `MLUT_WAYS << `MLUT_BKT_W;

    mlut_entry_t tbl [NENT];
    mlut_entry_t next_tbl [NENT];
    mlut_entry_t aged [NENT];
    mlut_entry_t hr, next_hr;
    mlut_state_t state, next_state;
    logic [31:0] idx0, next_idx0, idx1, next_idx1;
    logic [1:0] opc, next_opc;
    logic direct, next_direct, go, next_go, found, next_found, last, next_last;
    logic [11:0] ptr, next_ptr;
    logic [12:0] cnt, next_cnt;
    logic [31:0] next_rdata;
    logic next_done, next_hit, next_drop, next_af, next_wf, next_lf;
    logic [6:0] next_fwd;
    logic host_we;

    function automatic logic ent_valid(input mlut_entry_t e);
        return e.pinned || (e.prio_age != 3'h0);
    endfunction

    function automatic logic [9:0] hash(input logic [47:0] m, input logic [6:0] f,
                                        input logic en);
        return m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]}
            ^ (en ? {3'h0, f} : 10'h000);
    endfunction

    function automatic mlut_scan_t scan(input mlut_entry_t w0, input mlut_entry_t w1,
                                        input mlut_entry_t w2, input mlut_entry_t w3,
                                        input logic [47:0] m, input logic [6:0] f,
                                        input logic en);
        mlut_entry_t w [4];
        mlut_scan_t s;
        logic [2:0] best;
        w[0] = w0;
        w[1] = w1;
        w[2] = w2;
        w[3] = w3;
        s = '0;
        best = 3'h7;
        for (int i = 3; i >= 0; i--) begin
            if (ent_valid(w[i]) && w[i].mac == m && (!en || w[i].vlan_filter_group == f)) begin
                s.hit = 1'b1;
                s.hit_way = 2'(i);
            end
            if (!ent_valid(w[i])) begin
                s.free = 1'b1;
                s.free_way = 2'(i);
            end
            if (w[i].pinned) begin
                s.n_static = s.n_static + 3'h1;
            end else if (w[i].prio_age <= best) begin
                s.vict_ok = 1'b1;
                s.vict_way = 2'(i);
                best = w[i].prio_age;
            end
        end
        return s;
    endfunction

    // aging pass: dynamic counts step down, pinned entries untouched
    for (genvar g = 0; g < NENT; g++) begin : g_age
        always_comb begin
            aged[g] = tbl[g];
            if (!tbl[g].pinned && tbl[g].prio_age != 3'h0) begin
                aged[g].prio_age = tbl[g].prio_age - 3'h1;
            end
        end
    end

    logic [9:0] lk_bkt, h_bkt;
    mlut_scan_t lk_s, h_s;
    assign lk_bkt = hash(lk_mac_i, lk_fid_i, vlan_en_i);
    assign h_bkt = hash({idx0[15:0], idx1}, idx0[22:16], vlan_en_i);
    assign lk_s = scan(tbl[{lk_bkt, 2'h0}], tbl[{lk_bkt, 2'h1}], tbl[{lk_bkt, 2'h2}],
                       tbl[{lk_bkt, 2'h3}], lk_mac_i, lk_fid_i, vlan_en_i);
    assign h_s = scan(tbl[{h_bkt, 2'h0}], tbl[{h_bkt, 2'h1}], tbl[{h_bkt, 2'h2}],
                      tbl[{h_bkt, 2'h3}], {idx0[15:0], idx1}, idx0[22:16], vlan_en_i);

    always_comb begin
        logic [11:0] a;
        logic [11:0] la;
        mlut_entry_t ne;
        a = 12'h000;
        la = 12'h000;
        ne = '0;
        next_tbl = age_tick_i ? aged : tbl;
        next_hr = hr;
        next_state = state;
        next_idx0 = idx0;
        next_idx1 = idx1;
        next_opc = opc;
        next_direct = direct;
        next_go = go;
        next_found = found;
        next_last = last;
        next_ptr = ptr;
        next_cnt = cnt;
        next_done = 1'b0;
        next_hit = 1'b0;
        next_fwd = 7'h00;
        next_drop = 1'b0;
        next_af = 1'b0;
        next_wf = 1'b0;
        next_lf = 1'b0;
        host_we = 1'b0;
        next_rdata = `MLUT_RST_WORD;
        // forwarding lookups
        if (lk_req_i) begin
            la = {lk_bkt, lk_s.hit_way};
            next_done = 1'b1;
            if (lk_src_i) begin
                if (lk_s.hit) begin
                    next_hit = 1'b1;
                    next_drop = tbl[la].src_drop;
                    if (!tbl[la].pinned) begin
                        next_tbl[la].prio_age = AGE_RELOAD;
                        next_tbl[la].fwd = lk_port_i;
                    end
                end else if (lk_s.n_static == 3'h4) begin
                    next_lf = 1'b1;
                    next_idx1 = {idx1[31:10], lk_bkt};
                end else begin
                    la = {lk_bkt, lk_s.free ? lk_s.free_way : lk_s.vict_way};
                    ne.prio_age = AGE_RELOAD;
                    ne.fwd = lk_port_i;
                    ne.vlan_filter_group = lk_fid_i;
                    ne.mac = lk_mac_i;
                    next_tbl[la] = ne;
                end
            end else begin
                if (lk_s.hit && tbl[la].pinned) begin
                    next_hit = 1'b1;
                    next_fwd = tbl[la].fwd;
                    next_drop = tbl[la].dst_drop;
                end else if (st_hit_i) begin
                    next_hit = 1'b1;
                    next_fwd = st_fwd_i;
                end else if (lk_s.hit) begin
                    next_hit = 1'b1;
                    next_fwd = tbl[la].fwd;
                    next_drop = tbl[la].dst_drop;
                    next_tbl[la].prio_age = AGE_RELOAD;
                end
            end
        end
        // host engine
        unique case (state)
            S_IDLE: begin
                if (reg_wr_i && reg_addr_i == `MLUT_OFF_CTRL && reg_wdata_i[`MLUT_CTRL_GO]
                    && reg_wdata_i[1:0] != 2'h0) begin
                    next_go = 1'b1;
                    next_opc = reg_wdata_i[1:0];
                    next_direct = reg_wdata_i[`MLUT_CTRL_DIRECT];
                    next_found = 1'b0;
                    next_ptr = 12'h000;
                    next_cnt = 13'h0000;
                    next_last = 1'b0;
                    next_state = (reg_wdata_i[1:0] == `MLUT_OP_SEARCH) ? S_SCAN : S_RW;
                end
            end
            S_RW: begin
                a = direct ? idx1[11:0] : {h_bkt, h_s.hit_way};
                next_go = 1'b0;
                next_state = S_IDLE;
                if (opc == `MLUT_OP_READ) begin
                    next_found = direct ? ent_valid(tbl[a]) : h_s.hit;
                    next_hr = next_found ? tbl[a] : '0;
                end else if (hr.pinned) begin
                    next_found = 1'b1;
                    if (!direct && !h_s.hit) begin
                        if (h_s.n_static == 3'h4) begin
                            next_wf = 1'b1;
                            next_found = 1'b0;
                            next_idx0 = {idx0[31:10], h_bkt};
                        end else begin
                            a = {h_bkt, h_s.free ? h_s.free_way : h_s.vict_way};
                            if (h_s.n_static >= 3'h2) begin
                                next_af = 1'b1;
                                next_idx0 = {idx0[31:12], a};
                            end
                        end
                    end
                    if (!next_wf) begin
                        next_tbl[a] = hr;
                        host_we = 1'b1;
                    end
                end else begin
                    next_found = 1'b0;
                end
            end
            S_SCAN: begin
                next_ptr = ptr + 12'h001;
                if (ent_valid(tbl[ptr])) begin
                    next_hr = tbl[ptr];
                    next_found = 1'b1;
                    next_cnt = cnt + 13'h0001;
                    next_last = (ptr == 12'hFFF);
                    next_state = S_HOLD;
                end else if (ptr == 12'hFFF) begin
                    next_go = 1'b0;
                    next_hr = '0;
                    next_state = S_IDLE;
                end
            end
            S_HOLD: begin
                if (reg_rd_i && reg_addr_i == `MLUT_OFF_WORD4) begin
                    next_found = 1'b0;
                    next_state = last ? S_IDLE : S_SCAN;
                    next_go = !last;
                    next_hr = last ? '0 : hr;
                end
            end
        endcase
        if ((state == S_SCAN || state == S_HOLD) && reg_wr_i && reg_addr_i == `MLUT_OFF_CTRL
            && !reg_wdata_i[`MLUT_CTRL_GO]) begin
            next_go = 1'b0;
            next_state = S_IDLE;
            next_hr = '0;
        end
        // register writes, reserved bits dropped
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `MLUT_OFF_INDEX0: next_idx0 = {9'h000, reg_wdata_i[22:0]};
                `MLUT_OFF_INDEX1: next_idx1 = reg_wdata_i;
                `MLUT_OFF_WORD1: begin
                    {next_hr.pinned, next_hr.src_drop, next_hr.dst_drop} = reg_wdata_i[31:29];
                    next_hr.prio_age = reg_wdata_i[28:26];
                    next_hr.stg = reg_wdata_i[2:0];
                end
                `MLUT_OFF_WORD2: begin
                    next_hr.psa = reg_wdata_i[31];
                    next_hr.fwd = reg_wdata_i[6:0];
                end
                `MLUT_OFF_WORD3: begin
                    next_hr.vlan_filter_group = reg_wdata_i[22:16];
                    next_hr.mac[47:32] = reg_wdata_i[15:0];
                end
                `MLUT_OFF_WORD4: next_hr.mac[31:0] = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `MLUT_OFF_INDEX0: next_rdata = idx0;
                `MLUT_OFF_INDEX1: next_rdata = idx1;
                `MLUT_OFF_CTRL: next_rdata = {3'h0, cnt, 8'h00, go, found || !go,
                                              found, 2'h0, direct, opc};
                `MLUT_OFF_WORD1: next_rdata = {hr.pinned, hr.src_drop, hr.dst_drop,
                                               hr.prio_age, 23'h00_0000, hr.stg};
                `MLUT_OFF_WORD2: next_rdata = {hr.psa, 24'h00_0000, hr.fwd};
                `MLUT_OFF_WORD3: next_rdata = {9'h000, hr.vlan_filter_group, hr.mac[47:32]};
                `MLUT_OFF_WORD4: next_rdata = hr.mac[31:0];
                default: next_rdata = `MLUT_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NENT; i++) begin
                tbl[i] <= '0;
            end
            hr <= '0;
            state <= S_IDLE;
            idx0 <= `MLUT_RST_WORD;
            idx1 <= `MLUT_RST_WORD;
            opc <= 2'h0;
            direct <= 1'b0;
            go <= 1'b0;
            found <= 1'b0;
            last <= 1'b0;
            ptr <= 12'h000;
            cnt <= 13'h0000;
            reg_rdata_o <= `MLUT_RST_WORD;
            lk_done_o <= 1'b0;
            lk_hit_o <= 1'b0;
            lk_fwd_o <= 7'h00;
            lk_drop_o <= 1'b0;
            almost_full_o <= 1'b0;
            write_fail_o <= 1'b0;
            learn_fail_o <= 1'b0;
        end else if (ce_i) begin
            tbl <= next_tbl;
            hr <= next_hr;
            state <= next_state;
            idx0 <= next_idx0;
            idx1 <= next_idx1;
            opc <= next_opc;
            direct <= next_direct;
            go <= next_go;
            found <= next_found;
            last <= next_last;
            ptr <= next_ptr;
            cnt <= next_cnt;
            reg_rdata_o <= next_rdata;
            lk_done_o <= next_done;
            lk_hit_o <= next_hit;
            lk_fwd_o <= next_fwd;
            lk_drop_o <= next_drop;
            almost_full_o <= next_af;
            write_fail_o <= next_wf;
            learn_fail_o <= next_lf;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_rw_done: assert property (ce_i && state == S_RW |=> !go && state == S_IDLE)
        else $error("go not cleared after read or write");
    a_miss_zero: assert property (ce_i && state == S_RW && opc == `MLUT_OP_READ
        && !next_found |=> hr == '0 && !found)
        else $error("missed read left entry data");
    a_only_static: assert property (host_we |-> hr.pinned)
        else $error("host wrote a dynamic entry");
    a_search_begin: assert property (ce_i && state == S_IDLE && reg_wr_i
        && reg_addr_i == `MLUT_OFF_CTRL && reg_wdata_i[7] && reg_wdata_i[1:0] == 2'h3
        |=> state == S_SCAN && ptr == 12'h000 && !found && go)
        else $error("search did not start at top");
    a_word4_resume: assert property (ce_i && state == S_HOLD && reg_rd_i
        && reg_addr_i == `MLUT_OFF_WORD4 && !last && !reg_wr_i |=> state == S_SCAN && go)
        else $error("search did not resume after word 4");
    a_abort_go: assert property (ce_i && state == S_SCAN && reg_wr_i
        && reg_addr_i == `MLUT_OFF_CTRL && !reg_wdata_i[7] |=> !go && state == S_IDLE)
        else $error("search abort ignored");
    a_end_zero: assert property ($fell(go) && opc == `MLUT_OP_SEARCH |-> hr == '0)
        else $error("ended search left entry data");
    a_fosd_bit: assert property (ce_i && reg_rd_i && reg_addr_i == `MLUT_OFF_CTRL
        |=> reg_rdata_o[6] == ($past(found) || !$past(go)))
        else $error("combined status bit wrong");
    a_learn_fail: assert property (learn_fail_o |-> $past(lk_req_i && lk_src_i)
        && idx1[9:0] == $past(lk_bkt))
        else $error("learn fail without source lookup");
    a_static_wins: assert property (ce_i && lk_req_i && !lk_src_i && st_hit_i
        && !(lk_s.hit && tbl[{lk_bkt, lk_s.hit_way}].pinned) |=> lk_hit_o
        && lk_fwd_o == $past(st_fwd_i))
        else $error("dynamic result beat static");

    c_search_hit: cover property (state == S_SCAN ##1 state == S_HOLD);
    c_write_fail: cover property (write_fail_o);
    c_almost_full: cover property (almost_full_o);
    c_learn: cover property (lk_req_i && lk_src_i && !lk_s.hit);
endmodule

// file: verification/mlut_host.sv
/*
 * Host model for the address lookup table's register port.
 * Assumes strobes are taken on the rising edge and read data stands one cycle.
 */
`timescale 1ns/1ps
`include "mlut_params.svh"
module mlut_host (
    input wire logic clk_i,
    output logic [11:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [31:0] reg_wdata_o,
    input wire logic [31:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 12'h000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 32'h0000_0000;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        // released bus carries the inverse, not the last value
        reg_wdata_o = ~d;
    endtask

    // read data is zero outside its slot, so two cycles are or-ed
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
        @(negedge clk_i);
        d = d | reg_rdata_i;
    endtask

    task automatic ld_idx(input logic [47:0] m);
        wr(`MLUT_OFF_INDEX0, {16'h0000, m[47:32]});
        wr(`MLUT_OFF_INDEX1, m[31:0]);
    endtask

    // caller sets the pinned bit for a write that is to succeed
    task automatic put(input logic [127:0] e);
        wr(`MLUT_OFF_WORD1, e[127:96]);
        wr(`MLUT_OFF_WORD2, e[95:64]);
        wr(`MLUT_OFF_WORD3, e[63:32]);
        wr(`MLUT_OFF_WORD4, e[31:0]);
    endtask

    // words in order; the last read lets a search go on
    task automatic get(output logic [127:0] e);
        rd(`MLUT_OFF_WORD1, e[127:96]);
        rd(`MLUT_OFF_WORD2, e[95:64]);
        rd(`MLUT_OFF_WORD3, e[63:32]);
        rd(`MLUT_OFF_WORD4, e[31:0]);
    endtask

    task automatic poll(input int b, input logic v, output logic [31:0] c);
        for (int i = 0; i < 3000; i++) begin
            rd(`MLUT_OFF_CTRL, c);
            if (c[b] === v) break;
        end
    endtask

    task automatic op(input logic [1:0] code, input logic dir, output logic [31:0] c);
        wr(`MLUT_OFF_CTRL, {24'h00_0000, 1'b1, 4'h0, dir, code});
        poll(`MLUT_CTRL_GO, 1'b0, c);
    endtask
endmodule

// file: verification/tb_mac_address_lookup_table.sv
/*
 * Testbench: host model on the register port, lookups and aging driven here,
 * a keyed model of valid entries compared at every result.
 * Assumes one 10 MHz clock and an empty table after reset.
 */
`timescale 1ns/1ps
`include "mlut_params.svh"
module tb_mac_address_lookup_table;
    localparam logic [127:0] RSV = 128'h03FF_FFF8_7FFF_FF80_FF80_0000_0000_0000;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic age_tick_i = 1'b0;
    logic lk_req_i = 1'b0;
    logic lk_src_i = 1'b0;
    logic st_hit_i = 1'b0;
    logic [47:0] lk_mac_i = 48'h0000_0000_0000;
    logic [6:0] lk_port_i = 7'h04;
    logic [6:0] st_fwd_i = 7'h00;
    logic [11:0] reg_addr;
    logic reg_wr, reg_rd, lk_done, lk_hit, lk_drop, af, wf, lf;
    logic [31:0] reg_wdata, reg_rdata;
    logic [6:0] lk_fwd, gfwd;
    logic got = 1'b0;
    logic ghit, gdrop;
    int af_cnt = 0, wf_cnt = 0, lf_cnt = 0, failures = 0, n_compared = 0;
    int seed = 61201;
    logic [127:0] mdl [logic [47:0]];

    always #50 clk_i = ~clk_i;

    mlut_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .vlan_en_i(1'b0), .age_tick_i(age_tick_i), .lk_req_i(lk_req_i), .lk_src_i(lk_src_i),
        .lk_mac_i(lk_mac_i), .lk_fid_i(7'h00), .lk_port_i(lk_port_i), .st_hit_i(st_hit_i),
        .st_fwd_i(st_fwd_i), .lk_done_o(lk_done), .lk_hit_o(lk_hit), .lk_fwd_o(lk_fwd),
        .lk_drop_o(lk_drop), .almost_full_o(af), .write_fail_o(wf), .learn_fail_o(lf));
    mlut_host u_host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

    // one-cycle pulses are each seen once at the falling edge
    always @(negedge clk_i) begin
        if (lk_done) begin
            got = 1'b1;
            ghit = lk_hit;
            gfwd = lk_fwd;
            gdrop = lk_drop;
        end
        if (af) af_cnt++;
        if (wf) wf_cnt++;
        if (lf) lf_cnt++;
    end

    task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [47:0] rmac();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return r[47:0];
    endfunction

    // fl: pinned, source drop, destination drop, priority lsb
    function automatic logic [127:0] ent(input logic [47:0] m, input logic [6:0] f,
                                         input logic [3:0] fl);
        return {fl[3:1], 2'b10, fl[0], 23'h0, 3'h5, 1'b1, 24'h0, f, 16'h0000, m};
    endfunction

    task automatic hw(input logic [47:0] m, input logic [127:0] e, input logic ok);
        logic [31:0] c;
        u_host.ld_idx(m);
        u_host.put(e | RSV);
        u_host.op(`MLUT_OP_WRITE, 1'b0, c);
        chk("write_status", 128'({c[7], c[5]}), 128'({1'b0, ok}));
        if (ok) mdl[m] = e;
    endtask

    task automatic hr(input logic [47:0] m);
        logic [31:0] c;
        logic [127:0] w;
        logic f;
        f = mdl.exists(m);
        u_host.ld_idx(m);
        u_host.op(`MLUT_OP_READ, 1'b0, c);
        chk("read_status", 128'({c[7], c[6], c[5]}), 128'({2'b01, f}));
        u_host.get(w);
        chk("read_entry", w, f ? mdl[m] : 128'h0);
    endtask

    task automatic dput(input logic [11:0] a);
        logic [31:0] c;
        logic [47:0] m;
        m = rmac();
        mdl[m] = ent(m, 7'h7F, 4'h8);
        u_host.wr(`MLUT_OFF_INDEX1, 32'(a));
        u_host.put(mdl[m]);
        u_host.op(`MLUT_OP_WRITE, 1'b1, c);
        chk("direct_write", 128'(c[5]), 128'h1);
    endtask

    task automatic lk(input logic s, input logic [47:0] m, input logic sh, input logic [6:0] sf,
                      input logic [8:0] ex);
        @(negedge clk_i);
        got = 1'b0;
        lk_req_i = 1'b1;
        lk_src_i = s;
        lk_mac_i = m;
        st_hit_i = sh;
        st_fwd_i = sf;
        @(negedge clk_i);
        lk_req_i = 1'b0;
        lk_mac_i = ~m;
        repeat (2) @(negedge clk_i);
        #1;
        chk("lookup", 128'({got, ghit, gfwd, gdrop}), 128'({1'b1, ex}));
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk_i);
            age_tick_i = 1'b1;
            @(negedge clk_i);
            age_tick_i = 1'b0;
        end
    endtask

    task automatic summarize();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #10_000_000;
        failures++;
        summarize();
    end

    initial begin
        logic [47:0] ma, mb, mc, mx;
        logic [127:0] w;
        logic [31:0] c;
        logic [11:0] a, ad;
        int n;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        u_host.rd(12'h7FC, c);
        chk("unmapped", 128'(c), 128'h0);
        u_host.wr(`MLUT_OFF_CTRL, 32'h0000_0080);
        u_host.rd(`MLUT_OFF_CTRL, c);
        chk("idle_ctrl", 128'(c), 128'h40);
        $display("test reset done");
        ma = rmac();
        mb = rmac();
        hw(ma, ent(ma, 7'h15, 4'h9), 1'b1);
        hr(ma);
        hw(mb, ent(mb, 7'h2A, 4'h0), 1'b0);
        hr(mb);
        hw(mb, ent(mb, 7'h2A, 4'hE), 1'b1);
        lk(1'b0, ma, 1'b0, 7'h00, {1'b1, 7'h15, 1'b0});
        lk(1'b0, mb, 1'b0, 7'h00, {1'b1, 7'h2A, 1'b1});
        lk(1'b1, mb, 1'b0, 7'h00, {1'b1, 7'h00, 1'b1});
        $display("test static done");
        mc = rmac();
        lk(1'b1, mc, 1'b0, 7'h00, 9'h000);
        mdl[mc] = {3'b000, `MLUT_AGE_DEFAULT, 51'h0, 7'h04, 16'h0000, mc};
        hr(mc);
        lk(1'b0, mc, 1'b1, 7'h60, {1'b1, 7'h60, 1'b0});
        repeat (2) begin
            tick(6);
            lk(1'b0, mc, 1'b0, 7'h00, {1'b1, 7'h04, 1'b0});
        end
        tick(7);
        lk(1'b0, mc, 1'b0, 7'h00, 9'h000);
        mdl.delete(mc);
        hr(ma);
        $display("test aging done");
        mx = rmac();
        hw(mx, ent(mx, 7'h01, 4'h8), 1'b1);
        n = 0;
        for (int i = 0; i < 4096 && n == 0; i++) begin
            u_host.wr(`MLUT_OFF_INDEX1, 32'(i));
            u_host.op(`MLUT_OP_READ, 1'b1, c);
            u_host.rd(`MLUT_OFF_WORD4, c);
            if (c === mx[31:0]) begin
                a = i[11:0];
                n = 1;
            end
        end
        chk("slot_found", 128'(n), 128'h1);
        mdl.delete(mx);
        dput(a);
        dput({a[11:2], a[1:0] ^ 2'h1});
        n = af_cnt;
        hw(mx, ent(mx, 7'h01, 4'h8), 1'b1);
        chk("almost_full", 128'(af_cnt - n), 128'h1);
        u_host.rd(`MLUT_OFF_INDEX0, c);
        ad = c[11:0];
        chk("almost_full_bucket", 128'(ad[11:2]), 128'(a[11:2]));
        u_host.wr(`MLUT_OFF_INDEX1, 32'(ad));
        u_host.op(`MLUT_OP_READ, 1'b1, c);
        u_host.get(w);
        chk("almost_full_entry", w, mdl[mx]);
        dput({a[11:2], (ad[1:0] == (a[1:0] ^ 2'h2)) ? a[1:0] ^ 2'h3 : a[1:0] ^ 2'h2});
        dput(ad);
        mdl.delete(mx);
        n = wf_cnt;
        hw(mx, ent(mx, 7'h01, 4'h8), 1'b0);
        chk("write_fail", 128'(wf_cnt - n), 128'h1);
        u_host.rd(`MLUT_OFF_INDEX0, c);
        chk("write_fail_bucket", 128'(c[9:0]), 128'(a[11:2]));
        n = lf_cnt;
        lk(1'b1, mx, 1'b0, 7'h00, 9'h000);
        chk("learn_fail", 128'(lf_cnt - n), 128'h1);
        u_host.rd(`MLUT_OFF_INDEX1, c);
        chk("learn_fail_bucket", 128'(c[9:0]), 128'(a[11:2]));
        hr(mx);
        $display("test bucket done");
        u_host.wr(`MLUT_OFF_CTRL, 32'h0000_0083);
        u_host.wr(`MLUT_OFF_CTRL, 32'h0000_0003);
        u_host.rd(`MLUT_OFF_CTRL, c);
        chk("abort", 128'(c[7]), 128'h0);
        u_host.wr(`MLUT_OFF_CTRL, 32'h0000_0083);
        n = 0;
        for (int k = 0; k < 16; k++) begin
            u_host.poll(`MLUT_CTRL_FOSD, 1'b1, c);
            if (!c[5]) break;
            u_host.get(w);
            chk("search_entry", w, mdl.exists(w[47:0]) ? mdl[w[47:0]] : ~w);
            n++;
        end
        u_host.get(w);
        chk("search_end_words", w, 128'h0);
        u_host.rd(`MLUT_OFF_CTRL, c);
        chk("search_count", 128'({c[7], c[28:16]}), 128'(mdl.num()));
        chk("search_returned", 128'(n), 128'(mdl.num()));
        $display("test search done");
        summarize();
    end
endmodule
